// file: include/sic_pkg.sv
`default_nettype none
package sic_pkg;
  localparam logic [7:0] SIC_ADDR_LOW = 8'h0B;
  localparam logic [7:0] SIC_ADDR_HIGH = 8'h1E;
  localparam int SIC_NSRC = 6;
  localparam int SIC_ADDR_W = 8;
  localparam int SIC_VEC_W = 12;
  // Low register fields
  localparam int SIC_L_MASTER = 0;
  localparam int SIC_L_EN_A = 1;
  localparam int SIC_L_EN_B = 2;
  localparam int SIC_L_EN_CA = 3;
  localparam int SIC_L_F_A = 4;
  localparam int SIC_L_F_B = 5;
  localparam int SIC_L_F_CA = 6;
  // High register fields
  localparam int SIC_H_EN_CB = 0;
  localparam int SIC_H_EN_TB = 1;
  localparam int SIC_H_EN_RT = 2;
  localparam int SIC_H_F_CB = 4;
  localparam int SIC_H_F_TB = 5;
  localparam int SIC_H_F_RT = 6;
  localparam logic [7:0] SIC_RESET_VAL = 8'h00;
  localparam logic [SIC_VEC_W-1:0] SIC_VEC_EXT_A = 12'h004;
  localparam logic [SIC_VEC_W-1:0] SIC_VEC_EXT_B = 12'h008;
  localparam logic [SIC_VEC_W-1:0] SIC_VEC_CNT_A = 12'h00C;
  localparam logic [SIC_VEC_W-1:0] SIC_VEC_CNT_B = 12'h010;
  localparam logic [SIC_VEC_W-1:0] SIC_VEC_TICK = 12'h014;
  localparam logic [SIC_VEC_W-1:0] SIC_VEC_RTC = 12'h018;
  typedef enum logic [1:0] {SIC_IDLE, SIC_ACK} sic_state_type;
endpackage
`default_nettype wire

// file: include/sic_req_if.sv
`default_nettype none
interface sic_req_if #(parameter int N = 6);
  logic [N-1:0] pend;
  logic [N-1:0] grant;
  logic any;
  modport arb (input pend, output grant, output any);
  modport top (output pend, input grant, input any);
endinterface
`default_nettype wire

// file: rtl/sic_arbiter.sv
`default_nettype none
module sic_arbiter #(parameter int N = 6) (
  sic_req_if.arb bus
);
  // Carry chain needs at least two requesters
  if (N < 2) begin : g_n_check
    $error("sic_arbiter: N too small");
  end
  // Fixed priority: lowest index wins
  assign bus.grant = bus.pend & (~bus.pend + {{(N-1){1'b0}}, 1'b1});
  assign bus.any = |bus.pend;
endmodule
`default_nettype wire

// file: rtl/sic_controller.sv
// Summary of operation
// - Falling edge on external inputs sets low bits 4 and 5.
// - Enabled external flags vector to 04H or 08H when stack not full.
// - Accepting an interrupt clears its flag and the master enable.
// - Counter A overflow sets low bit 6, vectors to 0CH.
// - Counter B overflow sets high bit 4, vectors to 10H.
// - Time base tick sets high bit 5, vectors to 14H.
// - RTC tick sets high bit 6, vectors to 18H.
// - Further acks held until reenabling return or software reenable.
// - Reenabling return sets master enable; plain return leaves it.
// - Requests are serviced at the next second-phase edge.
// - Simultaneous requests serviced in fixed priority one to six.
// - Master enable low masks every source.
// - Low register: master, ext A, ext B, counter A enables; bit 7 zero.
// - High register: counter B, tick, RTC enables; bits 3, 7 zero.
// - Disabled sources still record their request flags.
// - Flags stay set until serviced or cleared by software.
// - Low register at 0BH, high at 1EH in data memory.
// - Full stack blocks acknowledgment until the pointer drops.
// - Only the program counter is pushed on acceptance.
// - Every source can wake the halted device.
`default_nettype none
module sic_controller
  import sic_pkg::*;
#(
  parameter int ADDR_W = SIC_ADDR_W
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic second_clock_phase_in,
  input wire logic ext_irq_in_a,
  input wire logic ext_irq_in_b,
  input wire logic counter_a_ovf_in,
  input wire logic counter_b_ovf_in,
  input wire logic tick_base_in,
  input wire logic rtc_tick_in,
  input wire logic stack_full_in,
  input wire logic ack_taken_in,
  input wire logic return_and_reenable_in,
  input wire logic plain_return_in,
  input wire logic halted_in,
  input wire logic [ADDR_W-1:0] mem_addr_in,
  input wire logic mem_wr_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_rdata_out,
  output logic irq_req_out,
  output logic [SIC_VEC_W-1:0] irq_vector_out,
  output logic push_pc_out,
  output logic wake_out
);
  // Both register locations need five address bits
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_addr_check
    $error("sic_controller: ADDR_W out of range");
  end

  logic [7:0] low_r, low_nxt, high_r, high_nxt;
  logic ext_a_prev_r, ext_b_prev_r;
  logic [SIC_NSRC-1:0] serviced_r, serviced_nxt;
  logic [7:0] rdata_nxt;
  logic irq_req_nxt, push_nxt, wake_nxt;
  logic [SIC_VEC_W-1:0] vec_nxt;
  sic_state_type state_r, state_nxt;

  wire sel_low = (mem_addr_in == SIC_ADDR_LOW[ADDR_W-1:0]);
  wire sel_high = (mem_addr_in == SIC_ADDR_HIGH[ADDR_W-1:0]);
  wire wr_low = mem_wr_in && sel_low;
  wire wr_high = mem_wr_in && sel_high;

  wire fall_a = ext_a_prev_r && !ext_irq_in_a;
  wire fall_b = ext_b_prev_r && !ext_irq_in_b;
  wire [SIC_NSRC-1:0] hw_set = {rtc_tick_in, tick_base_in, counter_b_ovf_in,
                                counter_a_ovf_in, fall_b, fall_a};

  wire master_irq_enable = low_r[SIC_L_MASTER];
  wire [SIC_NSRC-1:0] src_flag = {high_r[SIC_H_F_RT], high_r[SIC_H_F_TB],
                                  high_r[SIC_H_F_CB], low_r[SIC_L_F_CA],
                                  low_r[SIC_L_F_B], low_r[SIC_L_F_A]};
  wire [SIC_NSRC-1:0] src_en = {high_r[SIC_H_EN_RT], high_r[SIC_H_EN_TB],
                                high_r[SIC_H_EN_CB], low_r[SIC_L_EN_CA],
                                low_r[SIC_L_EN_B], low_r[SIC_L_EN_A]};

  // Master enable masks all; enables gate service only
  wire [SIC_NSRC-1:0] pend = (master_irq_enable && !stack_full_in) ?
                             (src_flag & src_en) : {SIC_NSRC{1'b0}};

  sic_req_if #(.N(SIC_NSRC)) arb_bus ();
  assign arb_bus.pend = pend;
  sic_arbiter #(.N(SIC_NSRC)) u_arb (.bus(arb_bus));
  wire [SIC_NSRC-1:0] grant = arb_bus.grant;

  // Decide only on a second-phase edge
  wire take = (state_r == SIC_IDLE) && second_clock_phase_in && arb_bus.any;

  wire [SIC_VEC_W-1:0] grant_vec =
    grant[0] ? SIC_VEC_EXT_A :
    grant[1] ? SIC_VEC_EXT_B :
    grant[2] ? SIC_VEC_CNT_A :
    grant[3] ? SIC_VEC_CNT_B :
    grant[4] ? SIC_VEC_TICK : SIC_VEC_RTC;

  always_comb begin
    state_nxt = state_r;
    serviced_nxt = {SIC_NSRC{1'b0}};
    irq_req_nxt = irq_req_out;
    vec_nxt = irq_vector_out;
    push_nxt = 1'b0;
    case (state_r)
      SIC_IDLE: begin
        if (take) begin
          state_nxt = SIC_ACK;
          irq_req_nxt = 1'b1;
          vec_nxt = grant_vec;
          serviced_nxt = grant;
        end
      end
      SIC_ACK: begin
        if (ack_taken_in) begin
          // Core pushes the program counter only
          state_nxt = SIC_IDLE;
          irq_req_nxt = 1'b0;
          push_nxt = 1'b1;
        end
      end
      default: state_nxt = SIC_IDLE;
    endcase
  end

  // Clear flag and master enable on accept
  // Flags held otherwise; hardware set wins over write
  wire [7:0] low_base = wr_low ? mem_wdata_in : low_r;
  wire [7:0] high_base = wr_high ? mem_wdata_in : high_r;
  wire [SIC_NSRC-1:0] flag_base = {high_base[SIC_H_F_RT], high_base[SIC_H_F_TB],
                                   high_base[SIC_H_F_CB], low_base[SIC_L_F_CA],
                                   low_base[SIC_L_F_B], low_base[SIC_L_F_A]};
  wire [SIC_NSRC-1:0] flag_nxt = (flag_base & ~serviced_nxt) | hw_set;
  wire master_en_nxt = return_and_reenable_in ? 1'b1 :
                       take ? 1'b0 : low_base[SIC_L_MASTER];

  always_comb begin
    // Low layout, bit 7 reads zero
    low_nxt = SIC_RESET_VAL;
    low_nxt[SIC_L_MASTER] = master_en_nxt;
    low_nxt[SIC_L_EN_A] = low_base[SIC_L_EN_A];
    low_nxt[SIC_L_EN_B] = low_base[SIC_L_EN_B];
    low_nxt[SIC_L_EN_CA] = low_base[SIC_L_EN_CA];
    low_nxt[SIC_L_F_A] = flag_nxt[0];
    low_nxt[SIC_L_F_B] = flag_nxt[1];
    low_nxt[SIC_L_F_CA] = flag_nxt[2];
    // High layout, bits 3 and 7 zero
    high_nxt = SIC_RESET_VAL;
    high_nxt[SIC_H_EN_CB] = high_base[SIC_H_EN_CB];
    high_nxt[SIC_H_EN_TB] = high_base[SIC_H_EN_TB];
    high_nxt[SIC_H_EN_RT] = high_base[SIC_H_EN_RT];
    high_nxt[SIC_H_F_CB] = flag_nxt[3];
    high_nxt[SIC_H_F_TB] = flag_nxt[4];
    high_nxt[SIC_H_F_RT] = flag_nxt[5];
  end

  assign rdata_nxt = sel_low ? low_nxt : sel_high ? high_nxt : SIC_RESET_VAL;
  // Any new request wakes a halted core
  assign wake_nxt = halted_in && (|hw_set);

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      low_r <= SIC_RESET_VAL;
      high_r <= SIC_RESET_VAL;
      ext_a_prev_r <= 1'b1;
      ext_b_prev_r <= 1'b1;
      state_r <= SIC_IDLE;
      serviced_r <= '0;
      mem_rdata_out <= SIC_RESET_VAL;
      irq_req_out <= 1'b0;
      irq_vector_out <= '0;
      push_pc_out <= 1'b0;
      wake_out <= 1'b0;
    end else if (clk_en_in) begin
      low_r <= low_nxt;
      high_r <= high_nxt;
      ext_a_prev_r <= ext_irq_in_a;
      ext_b_prev_r <= ext_irq_in_b;
      state_r <= state_nxt;
      serviced_r <= serviced_nxt;
      mem_rdata_out <= rdata_nxt;
      irq_req_out <= irq_req_nxt;
      irq_vector_out <= vec_nxt;
      push_pc_out <= push_nxt;
      wake_out <= wake_nxt;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  a_fall_sets_flag: assert property (clk_en_in && fall_a |=> low_r[SIC_L_F_A])
    else $error("ext A edge lost");
  a_vector_ext_b: assert property (take && grant[1] |=> irq_vector_out == SIC_VEC_EXT_B)
    else $error("wrong ext B vector");
  a_accept_clears: assert property (clk_en_in && take && !return_and_reenable_in
    |=> !low_r[SIC_L_MASTER])
    else $error("master enable not cleared");
  a_vector_rtc: assert property (take && grant[5] |=> irq_vector_out == SIC_VEC_RTC)
    else $error("wrong rtc vector");
  a_hold_in_ack: assert property (state_r == SIC_ACK |-> !take)
    else $error("second ack while busy");
  a_return_and_reenable_sets: assert property (clk_en_in && return_and_reenable_in
    |=> low_r[SIC_L_MASTER])
    else $error("reenable return ignored");
  a_phase_only: assert property (clk_en_in && !$past(irq_req_out) && irq_req_out
    |-> $past(second_clock_phase_in))
    else $error("ack off phase");
  a_prio_order: assert property (take && pend[0] |-> grant == 6'h01)
    else $error("priority broken");
  a_mask_all: assert property (!master_irq_enable |-> !take)
    else $error("masked ack");
  a_reserved_zero: assert property (!low_r[7] && !high_r[7] && !high_r[3])
    else $error("reserved bit set");
  a_stack_full: assert property (stack_full_in |-> !take)
    else $error("ack on full stack");
  a_hw_wins: assert property (clk_en_in && wr_high && rtc_tick_in
    |=> high_r[SIC_H_F_RT])
    else $error("set lost to write");

  a_fall_b_flag: assert property (
    clk_en_in && fall_b |=> low_r[SIC_L_F_B])
    else $error("ext B edge lost");
  a_vector_ext_a: assert property (
    clk_en_in && take && grant[0] |=> irq_vector_out == SIC_VEC_EXT_A)
    else $error("wrong ext A vector");
  a_vector_cnt_a: assert property (
    clk_en_in && take && grant[2] |=> irq_vector_out == SIC_VEC_CNT_A)
    else $error("wrong counter A vector");
  a_vector_cnt_b: assert property (
    clk_en_in && take && grant[3] |=> irq_vector_out == SIC_VEC_CNT_B)
    else $error("wrong counter B vector");
  a_vector_tick: assert property (
    clk_en_in && take && grant[4] |=> irq_vector_out == SIC_VEC_TICK)
    else $error("wrong tick vector");
  a_flag_cleared: assert property (
    clk_en_in && take && !(|(grant & hw_set)) && !wr_low && !wr_high
    |=> !(|(serviced_r & src_flag)))
    else $error("serviced flag kept");
  a_plain_keeps: assert property (
    clk_en_in && plain_return_in && !return_and_reenable_in && !take && !wr_low
    |=> low_r[SIC_L_MASTER] == $past(low_r[SIC_L_MASTER]))
    else $error("plain return changed master enable");
  a_req_holds: assert property (
    clk_en_in && irq_req_out && !ack_taken_in |=> irq_req_out)
    else $error("request dropped before ack");
  a_push_after: assert property (
    clk_en_in && state_r == SIC_ACK && ack_taken_in
    |=> push_pc_out && !irq_req_out)
    else $error("no push after ack");
  a_disabled_records: assert property (
    clk_en_in && counter_b_ovf_in && !high_r[SIC_H_EN_CB]
    |=> high_r[SIC_H_F_CB])
    else $error("disabled flag not recorded");
  a_flag_holds: assert property (
    clk_en_in && low_r[SIC_L_F_CA] && !wr_low && !serviced_nxt[2]
    |=> low_r[SIC_L_F_CA])
    else $error("flag lost");
  a_wake_any: assert property (
    clk_en_in && halted_in && (|hw_set) |=> wake_out)
    else $error("no wake");
  a_read_low: assert property (
    clk_en_in && sel_low |=> mem_rdata_out == low_r)
    else $error("low read wrong");
  a_read_other: assert property (
    clk_en_in && !sel_low && !sel_high |=> mem_rdata_out == SIC_RESET_VAL)
    else $error("unmapped read not zero");
  a_cnt_a_sets: assert property (
    clk_en_in && counter_a_ovf_in |=> low_r[SIC_L_F_CA])
    else $error("counter A flag lost");
  a_tick_sets: assert property (
    clk_en_in && tick_base_in |=> high_r[SIC_H_F_TB])
    else $error("tick flag lost");
  a_rtc_sets: assert property (
    clk_en_in && rtc_tick_in |=> high_r[SIC_H_F_RT])
    else $error("rtc flag lost");
  a_vector_stable: assert property (
    clk_en_in && irq_req_out |=> $stable(irq_vector_out))
    else $error("vector moved");
  a_mask_req: assert property (
    clk_en_in && state_r == SIC_IDLE && !master_irq_enable |=> !irq_req_out)
    else $error("request while masked");
  a_prio_second: assert property (
    take && pend[1] && !pend[0] |-> grant == 6'h02)
    else $error("priority two broken");
  a_full_no_req: assert property (
    clk_en_in && stack_full_in && state_r == SIC_IDLE |=> !irq_req_out)
    else $error("request on full stack");

  c_ext_a_taken: cover property (take && grant[0]);
  c_full_block: cover property (stack_full_in && master_irq_enable && |(src_flag & src_en));
  c_two_pending: cover property (take && $countones(pend) > 1);
  c_return_and_reenable: cover property (return_and_reenable_in && state_r == SIC_IDLE);
  c_wake: cover property (wake_out);
endmodule
`default_nettype wire

// file: testbench/sic_core_model.sv
`default_nettype none
module sic_core_model #(
  parameter int DEPTH = 6
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic irq_req_in,
  input wire logic push_pc_in,
  input wire logic return_in,
  input wire logic [3:0] delay_in,
  output logic ack_out,
  output logic full_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  logic [2:0] depth_r;
  assign full_out = (depth_r == 3'(DEPTH));
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_out <= 1'b0;
      wait_r <= 4'h0;
      depth_r <= 3'h0;
    end else begin
      // Delay lets the fetch be prompt or slow
      ack_out <= irq_req_in && !ack_out && (wait_r >= delay_in);
      wait_r <= (irq_req_in && !ack_out) ? wait_r + 4'h1 : 4'h0;
      if (push_pc_in && !return_in)
        depth_r <= depth_r + 3'h1;
      else if (return_in && !push_pc_in && depth_r != 3'h0)
        depth_r <= depth_r - 3'h1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sic_pkg::*;
  logic mclk_in = 0, reset_in = 1, clk_en_in = 1, second_clock_phase_in = 1;
  logic ext_irq_in_a = 1, ext_irq_in_b = 1, counter_a_ovf_in = 0, counter_b_ovf_in = 0;
  logic tick_base_in = 0, rtc_tick_in = 0, halted_in = 0, mem_wr_in = 0;
  logic return_and_reenable_in = 0, plain_return_in = 0, stack_full_in, ack_taken_in;
  logic [7:0] mem_addr_in = 0, mem_wdata_in = 0, mem_rdata_out;
  logic irq_req_out, push_pc_out, wake_out;
  logic [SIC_VEC_W-1:0] irq_vector_out;
  logic [3:0] dly = 0;
  logic [31:0] seed = 32'h00010E27;
  logic [31:0] r;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  sic_controller sic_controller_inst (.mclk_in, .reset_in, .clk_en_in, .second_clock_phase_in,
    .ext_irq_in_a, .ext_irq_in_b, .counter_a_ovf_in, .counter_b_ovf_in, .tick_base_in,
    .rtc_tick_in, .stack_full_in, .ack_taken_in, .return_and_reenable_in, .plain_return_in,
    .halted_in, .mem_addr_in, .mem_wr_in, .mem_wdata_in, .mem_rdata_out, .irq_req_out,
    .irq_vector_out, .push_pc_out, .wake_out);
  sic_core_model sic_core_model_inst (.mclk_in, .reset_in, .irq_req_in(irq_req_out),
    .push_pc_in(push_pc_out), .return_in(return_and_reenable_in | plain_return_in),
    .delay_in(dly), .ack_out(ack_taken_in), .full_out(stack_full_in));
  initial forever #5 mclk_in = ~mclk_in;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [SIC_VEC_W-1:0] vec_of(input int i);
    return SIC_VEC_W'(4 * (i + 1));
  endfunction
  // Low register after servicing source i of the first three
  function automatic logic [7:0] low_left(input int i);
    low_left = 8'h0E;
    for (int j = i + 1; j < 3; j++) low_left[4 + j] = 1'b1;
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    mem_addr_in <= a;
    mem_wr_in <= 1'b1;
    mem_wdata_in <= d;
    @(posedge mclk_in);
    mem_wr_in <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    mem_addr_in <= a;
    @(posedge mclk_in);
    #1 `CHK(mem_rdata_out, e)
  endtask
  task automatic fire(input logic [5:0] m);
    @(posedge mclk_in);
    ext_irq_in_a <= ~m[0];
    ext_irq_in_b <= ~m[1];
    counter_a_ovf_in <= m[2];
    counter_b_ovf_in <= m[3];
    tick_base_in <= m[4];
    rtc_tick_in <= m[5];
    @(posedge mclk_in);
    {ext_irq_in_a, ext_irq_in_b} <= 2'h3;
    {counter_a_ovf_in, counter_b_ovf_in, tick_base_in, rtc_tick_in} <= 4'h0;
  endtask
  task automatic do_return(input bit re);
    @(posedge mclk_in);
    if (re) return_and_reenable_in <= 1'b1;
    else plain_return_in <= 1'b1;
    @(posedge mclk_in);
    {return_and_reenable_in, plain_return_in} <= 2'h0;
  endtask
  task automatic take(input logic [SIC_VEC_W-1:0] v);
    int n;
    n = 0;
    dly <= 4'(xs());
    #1;
    while (irq_req_out !== 1'b1 && n < 40) begin
      @(posedge mclk_in);
      #1 n++;
    end
    `CHK(irq_vector_out, v)
    while (push_pc_out !== 1'b1 && n < 80) begin
      @(posedge mclk_in);
      #1 n++;
    end
    `CHK(push_pc_out, 1'b1)
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      #1 `CHK(irq_req_out, 1'b0)
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    rreg(SIC_ADDR_LOW, 8'h00);
    rreg(SIC_ADDR_HIGH, 8'h00);
    r = xs();
    wreg(SIC_ADDR_LOW, {4'h8, r[3:0]});
    rreg(SIC_ADDR_LOW, {4'h0, r[3:0]});
    wreg(SIC_ADDR_HIGH, {5'h11, r[10:8]});
    rreg(SIC_ADDR_HIGH, {5'h00, r[10:8]});
    wreg(8'h0C, 8'hFF);
    rreg(8'h0C, 8'h00);
    wreg(SIC_ADDR_LOW, 8'h0E);
    wreg(SIC_ADDR_HIGH, 8'h07);
    fire(6'h3F);
    rreg(SIC_ADDR_LOW, 8'h7E);
    rreg(SIC_ADDR_HIGH, 8'h77);
    quiet(4);
    for (int i = 0; i < 6; i++) begin
      do_return(1'b1);
      take(vec_of(i));
      if (i < 3) rreg(SIC_ADDR_LOW, low_left(i));
    end
    do_return(1'b0);
    rreg(SIC_ADDR_LOW, 8'h0E);
    @(posedge mclk_in);
    second_clock_phase_in <= 1'b0;
    fire(6'h04);
    do_return(1'b1);
    quiet(6);
    second_clock_phase_in <= 1'b1;
    take(SIC_VEC_CNT_A);
    for (int k = 0; k < 6; k++) begin
      wreg(SIC_ADDR_LOW, 8'h09);
      fire(6'h04);
      if (k < 5) take(SIC_VEC_CNT_A);
      else quiet(8);
    end
    do_return(1'b0);
    take(SIC_VEC_CNT_A);
    halted_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      fire(6'(1 << i));
      #1 r = 0;
      while (wake_out !== 1'b1 && r < 4) begin
        @(posedge mclk_in);
        #1 r++;
      end
      `CHK(wake_out, 1'b1)
    end
    final_report();
  end
endmodule
`default_nettype wire
